// [logic/shifter_pkg.sv]
// Constants for the shifter field and pack unit.
// Assumes an APB slave with 32-bit data and 12-bit byte addresses.
`default_nettype none
package shifter_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] OPERAND_OFS = 12'h000;
    localparam logic [11:0] CONTROL_OFS = 12'h004;
    localparam logic [11:0] COMMAND_OFS = 12'h008;
    localparam logic [11:0] RESULT_FIXED_OFS = 12'h00C;
    localparam logic [11:0] RESULT_EXT_OFS = 12'h010;
    localparam logic [11:0] FLAGS_OFS = 12'h014;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POS_LSB = 0;
    localparam int LEN_LSB = 6;
    localparam int OPSEL_LSB = 0;
    localparam int ALU_OVF_BIT = 8;
    localparam int ZERO_BIT = 0;
    localparam int OVF_BIT = 1;
    localparam int SIGN_BIT = 2;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] OPERAND_RST = 32'h0000_0000;
    localparam logic [5:0] FIELD_RST = 6'h00;
    localparam logic [39:0] RESULT_RST = 40'h00_0000_0000;
    // ************************************************************
    // Number format limits
    // ************************************************************
    localparam logic [6:0] FIXED_WIDTH = 7'h20;
    localparam logic [7:0] PACK_SAT_EXP = 8'h87;
    localparam logic [7:0] PACK_NORM_EXP = 8'h78;
    localparam logic [7:0] PACK_DENORM_EXP = 8'h6D;
    localparam logic [7:0] PACK_SHIFT_BASE = 8'h85;
    localparam logic [7:0] EXPAND_EXP_BASE = 8'h78;
    // ************************************************************
    // Operations
    // ************************************************************
    typedef enum logic [2:0] {
        OP_FIELD_EXTRACT = 3'h0,
        OP_FIELD_EXTRACT_SIGN = 3'h1,
        OP_EXPONENT = 3'h2,
        OP_EXPONENT_OVF = 3'h3,
        OP_COUNT_ZEROS = 3'h4,
        OP_COUNT_ONES = 3'h5,
        OP_COMPRESS = 3'h6,
        OP_EXPAND = 3'h7
    } op_type;
endpackage
`default_nettype wire

// [logic/shifter_field_and_pack_unit.sv]
// Shifter datapath: field extract, exponent, leading counts, short floats.
// Assumes an APB master on pclk; one transfer at a time.
//
// Notes on behaviour
// - Zero-fill extract clears bits above the field and the extension byte.
// - Position and length accept 0..63; field lengths 0..32.
// - Extract sets overflow when length plus position exceeds 32; zero; sign cleared.
// - Field taken at position, with length, right-aligned in fixed part.
// - Sign variant fills upper bits with field top bit unless off-scale left.
// - Exponent is twos complement of leading sign bits minus one.
// - Plain exponent: zero on zero exponent, overflow cleared, sign is bit 31.
// - Overflow-aware exponent gives +1 when ALU overflow is set.
// - Overflow-aware sign is ALU overflow xor bit 31; zero; overflow cleared.
// - Leading zero count into position field; flags from MSB and count 32.
// - Leading one count into position field; flags from MSB and count 32.
// - Compress to sign, 4-bit exponent, 11-bit mantissa in low 16 bits.
// - Biased exponent above 135 gives largest magnitude, sign kept.
// - Exponent 121..135: MSB plus three LSBs, rounded upper 11 fraction bits.
// - Exponent 110..120: zero exponent, rounded shifted fraction with hidden one.
// - Exponent below 110 gives an all-zero magnitude.
// - Compress sets overflow on overflow; zero and sign cleared.
// - Expand nonzero exponent: MSB, four inverted MSBs, three LSBs; 12 zeros.
// - Expand zero exponent: 120 minus leading zeros, normalised; flags cleared.
// - Compress and expand complete in one clock.
`timescale 1ns/10ps
`default_nettype none
module shifter_field_and_pack_unit (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Result and flags
    output logic [39:0] result,
    output logic shifter_zero_flag,
    output logic shifter_overflow_flag,
    output logic shifter_sign_flag
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [31:0] operand;
        logic [5:0] field_position;
        logic [5:0] field_length;
        logic [2:0] opsel;
        logic alu_overflow_flag;
        logic [39:0] result;
        logic zf;
        logic vf;
        logic sf;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } state_type;

    state_type st;
    state_type next_st;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [5:0] lead_count(input logic [31:0] v, input logic b);
        logic [5:0] n;
        logic stop;
        n = 6'h00;
        stop = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (!stop && v[i] == b) begin
                n = n + 6'h01;
            end else begin
                stop = 1'b1;
            end
        end
        return n;
    endfunction

    // Returns {overflow, value}
    function automatic logic [32:0] extract(input logic [31:0] v, input logic [5:0] pos,
                                            input logic [5:0] len, input logic fill_sign);
        logic [63:0] wide;
        logic [31:0] mask;
        logic [31:0] val;
        logic [6:0] top;
        logic sgn;
        wide = {32'h0000_0000, v} >> pos;
        mask = (len >= 6'h20) ? 32'hFFFF_FFFF : ~(32'hFFFF_FFFF << len);
        val = wide[31:0] & mask;
        top = {1'b0, pos} + {1'b0, len};
        // Off-scale left top bit means no sign fill
        sgn = (len != 6'h00) && (top <= shifter_pkg::FIXED_WIDTH) && v[top[4:0] - 5'h01];
        if (fill_sign && sgn) begin
            val = val | ~mask;
        end
        return {top > shifter_pkg::FIXED_WIDTH, val};
    endfunction

    // Returns {overflow, short float}
    function automatic logic [16:0] compress(input logic [31:0] v);
        logic [7:0] e;
        logic [15:0] sum;
        logic [23:0] man;
        logic [23:0] t;
        logic [23:0] r;
        logic [4:0] sh;
        e = v[30:23];
        man = {1'b1, v[22:0]};
        sum = 16'h0000;
        t = 24'h00_0000;
        r = 24'h00_0000;
        sh = 5'h00;
        if (e > shifter_pkg::PACK_SAT_EXP) begin
            return {1'b1, v[31], 15'h7FFF};
        end else if (e > shifter_pkg::PACK_NORM_EXP) begin
            sum = {1'b0, e[7], e[2:0], v[22:12]} + {15'h0000, v[11]};
            // Rounding that carries past the top exponent saturates
            if (sum[15]) begin
                return {1'b1, v[31], 15'h7FFF};
            end
            return {1'b0, v[31], sum[14:0]};
        end else if (e > shifter_pkg::PACK_DENORM_EXP) begin
            sh = 5'(shifter_pkg::PACK_SHIFT_BASE - e);
            t = man >> sh;
            r = man >> (sh - 5'h01);
            // A carry out of the mantissa lands in the exponent as a normal 1
            return {1'b0, v[31], 15'({4'h0, t[10:0]} + {14'h0000, r[0]})};
        end
        return {1'b0, v[31], 15'h0000};
    endfunction

    function automatic logic [31:0] expand(input logic [15:0] v);
        logic [3:0] e4;
        logic [10:0] m;
        logic [5:0] n;
        logic [10:0] norm;
        e4 = v[14:11];
        m = v[10:0];
        n = lead_count({m, 21'h1F_FFFF}, 1'b0);
        norm = m << (n + 6'h01);
        if (e4 != 4'h0) begin
            return {v[15], e4[3], {4{~e4[3]}}, e4[2:0], m, 12'h000};
        end else if (m == 11'h000) begin
            return {v[15], 31'h0000_0000};
        end
        return {v[15], 8'(shifter_pkg::EXPAND_EXP_BASE - {2'b00, n}), norm, 12'h000};
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    logic access;
    logic commit;
    logic [31:0] rd;
    logic err;
    logic [32:0] ext;
    logic [5:0] cnt;
    logic [7:0] expo;
    logic [16:0] pk;

    always_comb begin
        next_st = st;
        access = psel && penable;
        commit = access && st.ready;
        rd = 32'h0000_0000;
        err = 1'b0;
        ext = 33'h0_0000_0000;
        cnt = 6'h00;
        expo = 8'h00;
        pk = 17'h0_0000;
        if (paddr == shifter_pkg::OPERAND_OFS) begin
            rd = st.operand;
        end else if (paddr == shifter_pkg::CONTROL_OFS) begin
            rd = {20'h0_0000, st.field_length, st.field_position};
        end else if (paddr == shifter_pkg::COMMAND_OFS) begin
            rd = {23'h00_0000, st.alu_overflow_flag, 5'h00, st.opsel};
        end else if (paddr == shifter_pkg::RESULT_FIXED_OFS) begin
            rd = st.result[39:8];
            err = pwrite;
        end else if (paddr == shifter_pkg::RESULT_EXT_OFS) begin
            rd = {24'h00_0000, st.result[7:0]};
            err = pwrite;
        end else if (paddr == shifter_pkg::FLAGS_OFS) begin
            rd = {29'h0000_0000, st.sf, st.vf, st.zf};
            err = pwrite;
        end else begin
            err = 1'b1;
        end
        // One wait state keeps every bus output on a flop
        next_st.ready = access && !st.ready;
        if (access && !st.ready) begin
            next_st.rdata = pwrite ? 32'h0000_0000 : rd;
            next_st.slverr = err;
        end else begin
            next_st.slverr = 1'b0;
        end
        if (commit && pwrite && !st.slverr) begin
            if (paddr == shifter_pkg::OPERAND_OFS) begin
                next_st.operand = pwdata;
            end else if (paddr == shifter_pkg::CONTROL_OFS) begin
                next_st.field_position = pwdata[shifter_pkg::POS_LSB +: 6];
                next_st.field_length = pwdata[shifter_pkg::LEN_LSB +: 6];
            end else if (paddr == shifter_pkg::COMMAND_OFS) begin
                next_st.opsel = pwdata[shifter_pkg::OPSEL_LSB +: 3];
                next_st.alu_overflow_flag = pwdata[shifter_pkg::ALU_OVF_BIT];
                next_st.result = shifter_pkg::RESULT_RST;
                next_st.zf = 1'b0;
                next_st.vf = 1'b0;
                next_st.sf = 1'b0;
                // The whole operation finishes at this edge
                case (shifter_pkg::op_type'(pwdata[shifter_pkg::OPSEL_LSB +: 3]))
                    shifter_pkg::OP_FIELD_EXTRACT, shifter_pkg::OP_FIELD_EXTRACT_SIGN: begin
                        ext = extract(st.operand, st.field_position, st.field_length, pwdata[0]);
                        next_st.result[39:8] = ext[31:0];
                        next_st.zf = ext[31:0] == 32'h0000_0000;
                        next_st.vf = ext[32];
                    end
                    shifter_pkg::OP_EXPONENT, shifter_pkg::OP_EXPONENT_OVF: begin
                        cnt = lead_count(st.operand, st.operand[31]);
                        expo = 8'h01 - {2'b00, cnt};
                        if (pwdata[0] && pwdata[shifter_pkg::ALU_OVF_BIT]) begin
                            expo = 8'h01;
                        end
                        next_st.result[15:8] = expo;
                        next_st.zf = expo == 8'h00;
                        next_st.sf = st.operand[31] ^ (pwdata[0] && pwdata[shifter_pkg::ALU_OVF_BIT]);
                    end
                    shifter_pkg::OP_COUNT_ZEROS, shifter_pkg::OP_COUNT_ONES: begin
                        cnt = lead_count(st.operand, pwdata[0]);
                        next_st.result[13:8] = cnt;
                        next_st.zf = st.operand[31] != pwdata[0];
                        next_st.vf = cnt == 6'h20;
                    end
                    shifter_pkg::OP_COMPRESS: begin
                        pk = compress(st.operand);
                        next_st.result[23:8] = pk[15:0];
                        next_st.vf = pk[16];
                    end
                    default: begin
                        next_st.result[39:8] = expand(st.operand[15:0]);
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.operand <= shifter_pkg::OPERAND_RST;
            st.field_position <= shifter_pkg::FIELD_RST;
            st.field_length <= shifter_pkg::FIELD_RST;
            st.opsel <= 3'h0;
            st.alu_overflow_flag <= 1'b0;
            st.result <= shifter_pkg::RESULT_RST;
            st.zf <= 1'b0;
            st.vf <= 1'b0;
            st.sf <= 1'b0;
            st.rdata <= 32'h0000_0000;
            st.ready <= 1'b0;
            st.slverr <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign result = st.result;
    assign shifter_zero_flag = st.zf;
    assign shifter_overflow_flag = st.vf;
    assign shifter_sign_flag = st.sf;

    // ************************************************************
    // Checks
    // ************************************************************
    logic go;
    logic [2:0] op_w;
    assign go = commit && pwrite && !st.slverr && paddr == shifter_pkg::COMMAND_OFS;
    assign op_w = pwdata[2:0];

    chk_extract_ext_zero: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h0 |=> result[7:0] == 8'h00 && (st.field_length >= 6'h20 ||
        (result[39:8] >> st.field_length) == 32'h0000_0000))
        else $error("zero-fill extract left bits above field");
    chk_extract_overflow: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w[2:1] == 2'b00 |=> shifter_overflow_flag ==
        (({1'b0, st.field_position} + {1'b0, st.field_length}) > 7'h20) && !shifter_sign_flag)
        else $error("extract overflow or sign flag wrong");
    chk_extract_zero: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w[2:1] == 2'b00 |=> shifter_zero_flag == (result == 40'h00_0000_0000))
        else $error("extract zero flag wrong");
    chk_exponent_sign: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h2 |=> shifter_sign_flag == $past(st.operand[31]) && !shifter_overflow_flag)
        else $error("exponent sign flag wrong");
    chk_ovf_exponent: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h3 && pwdata[8] |=> result[15:8] == 8'h01 && !shifter_zero_flag)
        else $error("overflow exponent not one");
    chk_count_full: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h4 && st.operand == 32'h0000_0000 |=> result[13:8] == 6'h20 &&
        shifter_overflow_flag && !shifter_zero_flag)
        else $error("leading zero count of zero wrong");
    chk_ones_zero: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h5 |=> shifter_zero_flag == !$past(st.operand[31]) && !shifter_sign_flag)
        else $error("leading one zero flag wrong");
    chk_pack_under: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h6 && st.operand[30:23] < 8'h6E |=> result[22:8] == 15'h0000 &&
        !shifter_zero_flag && !shifter_sign_flag)
        else $error("compress underflow not zero");
    chk_unpack_flags: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h7 |=> !shifter_zero_flag && !shifter_overflow_flag && !shifter_sign_flag)
        else $error("expand flags not cleared");
    chk_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

    chk_field_aligned: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w[2:1] == 2'b00 && st.field_position == 6'h00 && st.field_length == 6'h20 |=>
        result[39:8] == $past(st.operand))
        else $error("full-width extract not a copy");

    chk_sign_fill_top: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h1 && st.field_length != 6'h00 && st.field_length < 6'h20 &&
        ({1'b0, st.field_position} + {1'b0, st.field_length}) <= 7'h20 &&
        st.operand[5'(st.field_position + st.field_length - 6'h01)] |=> result[39])
        else $error("sign fill missing");

    chk_exponent_zero: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h2 |=> shifter_zero_flag == (result[15:8] == 8'h00) &&
        result[39:16] == 24'h00_0000)
        else $error("exponent zero flag or upper bits wrong");

    chk_ovf_exp_sign: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h3 |=> shifter_sign_flag == ($past(pwdata[8]) ^ $past(st.operand[31])) &&
        !shifter_overflow_flag)
        else $error("overflow-aware exponent sign wrong");

    chk_zeros_msb: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h4 |=> shifter_zero_flag == $past(st.operand[31]) && !shifter_sign_flag)
        else $error("leading zero flags wrong");

    chk_ones_full: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h5 && st.operand == 32'hFFFF_FFFF |=> result[13:8] == 6'h20 &&
        shifter_overflow_flag)
        else $error("leading one count of ones wrong");

    chk_pack_saturate: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h6 && st.operand[30:23] > 8'h87 |=> result[22:8] == 15'h7FFF &&
        shifter_overflow_flag && result[23] == $past(st.operand[31]))
        else $error("compress saturation wrong");

    chk_pack_flags: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h6 |=> !shifter_zero_flag && !shifter_sign_flag &&
        result[39:24] == 16'h0000)
        else $error("compress flags or upper bits wrong");

    chk_unpack_normal: assert property (@(posedge pclk) disable iff (!presetn)
        go && op_w == 3'h7 && st.operand[14:11] != 4'h0 |=>
        result[37:34] == {4{~result[38]}} && result[19:8] == 12'h000)
        else $error("expand normal exponent wrong");

    chk_ext_byte_zero: assert property (@(posedge pclk) disable iff (!presetn)
        go |=> result[7:0] == 8'h00)
        else $error("extension byte not zero");

endmodule
`default_nettype wire

// [testbench/shifter_field_and_pack_unit_bench.sv]
// Self-checking bench for the shifter field and pack unit.
// Assumes the unit answers APB transfers on pclk and updates result and flags when a command is written.
`timescale 1ns/10ps
`default_nettype none
module shifter_field_and_pack_unit_bench;
    // ************************************************************
    // Signals
    // ************************************************************
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [39:0] result;
    logic shifter_zero_flag;
    logic shifter_overflow_flag;
    logic shifter_sign_flag;
    int mismatches;
    int compares;

    shifter_field_and_pack_unit dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .result(result),
        .shifter_zero_flag(shifter_zero_flag), .shifter_overflow_flag(shifter_overflow_flag),
        .shifter_sign_flag(shifter_sign_flag)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ************************************************************
    // Reference model
    // ************************************************************
    function automatic int lead(input logic [31:0] s, input logic b);
        int k;
        k = 0;
        while (k < 32 && s[31 - k] == b) k++;
        return k;
    endfunction

    // Returns {sign, overflow, zero, result}
    function automatic logic [42:0] model(input logic [2:0] op, input logic av, input logic [31:0] s,
        input logic [5:0] p, input logic [5:0] l);
        logic [63:0] m;
        logic [31:0] x;
        logic [23:0] sig;
        logic [15:0] c;
        logic [7:0] e;
        logic z, v, g;
        int n;
        x = 32'h0;
        v = 1'b0;
        g = 1'b0;
        c = 16'h0;
        e = s[30:23];
        case (op)
            3'h0, 3'h1: begin
                m = (64'h1 << l) - 64'h1;
                x = 32'(({32'h0, s} >> p) & m);
                v = (int'(p) + int'(l)) > 32;
                // Off-scale fields keep zero fill
                if (op == 3'h1 && l != 6'h00 && !v && s[int'(p) + int'(l) - 1])
                    x = x | ~m[31:0];
                z = (x == 32'h0);
            end
            3'h2, 3'h3: begin
                n = lead(s, s[31]);
                x = {24'h0, 8'(1 - n)};
                if (op == 3'h3 && av)
                    x = 32'h1;
                z = (x == 32'h0);
                g = (op == 3'h3) ? (av ^ s[31]) : s[31];
            end
            3'h4, 3'h5: begin
                n = lead(s, op[0]);
                x = 32'(n);
                v = (n == 32);
                z = s[31] ^ op[0];
            end
            3'h6: begin
                if (e > shifter_pkg::PACK_SAT_EXP)
                    v = 1'b1;
                else if (e > shifter_pkg::PACK_NORM_EXP)
                    {v, c[14:0]} = {1'b0, e[7], e[2:0], s[22:12]} + 16'(s[11]);
                else if (e > shifter_pkg::PACK_DENORM_EXP) begin
                    // Keep one extra bit below the mantissa for rounding
                    sig = {1'b1, s[22:0]} >> (shifter_pkg::PACK_SHIFT_BASE - e - 8'h1);
                    {v, c[14:0]} = 16'(sig[23:1]) + 16'(sig[0]);
                end
                if (v)
                    c[14:0] = 15'h7FFF;
                c[15] = s[31];
                x = {16'h0, c};
                z = 1'b0;
            end
            default: begin
                c = s[15:0];
                n = lead({c[10:0], 21'h0}, 1'b0);
                z = 1'b0;
                if (c[14:11] != 4'h0)
                    x = {c[15], c[14], {4{~c[14]}}, c[13:11], c[10:0], 12'h0};
                else if (c[10:0] == 11'h0)
                    x = {c[15], 31'h0};
                else begin
                    m = 64'({c[10:0], 21'h0}) << (n + 1);
                    x = {c[15], 8'(shifter_pkg::EXPAND_EXP_BASE - 8'(n)), m[31:9]};
                end
            end
        endcase
        return {g, v, z, x, 8'h00};
    endfunction

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [42:0] seen, input logic [42:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            give_verdict();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_op(input logic [2:0] op, input logic av, input logic [31:0] s,
        input logic [5:0] p, input logic [5:0] l);
        logic [42:0] ex;
        logic [31:0] r;
        logic err;
        ex = model(op, av, s, p, l);
        apb(1'b1, shifter_pkg::OPERAND_OFS, s, r, err);
        apb(1'b1, shifter_pkg::CONTROL_OFS, {20'h0, l, p}, r, err);
        apb(1'b1, shifter_pkg::COMMAND_OFS, {23'h0, av, 5'h0, op}, r, err);
        #1;
        check({shifter_sign_flag, shifter_overflow_flag, shifter_zero_flag, result}, ex);
        apb(1'b0, shifter_pkg::FLAGS_OFS, 32'h0, r, err);
        check({40'h0, r[2:0]}, {40'h0, ex[42:40]});
        apb(1'b0, shifter_pkg::RESULT_FIXED_OFS, 32'h0, r, err);
        check({11'h0, r}, {11'h0, ex[39:8]});
        apb(1'b0, shifter_pkg::RESULT_EXT_OFS, 32'h0, r, err);
        check({11'h0, r}, 43'h0);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    logic [47:0] corners [20] = '{
        {3'h0, 1'b0, 32'hFFFF_FFFF, 6'h00, 6'h00}, {3'h0, 1'b0, 32'hFFFF_FFFF, 6'h3F, 6'h3F},
        {3'h1, 1'b0, 32'h8000_0000, 6'h00, 6'h20}, {3'h1, 1'b0, 32'hF000_0000, 6'h1C, 6'h08},
        {3'h1, 1'b0, 32'h0000_0080, 6'h04, 6'h04}, {3'h0, 1'b0, 32'hABCD_1234, 6'h0D, 6'h0E},
        {3'h2, 1'b0, 32'h0000_0000, 6'h00, 6'h00}, {3'h3, 1'b1, 32'h8000_0000, 6'h00, 6'h00},
        {3'h3, 1'b1, 32'h4000_0000, 6'h00, 6'h00}, {3'h2, 1'b0, 32'hC000_0000, 6'h00, 6'h00},
        {3'h4, 1'b0, 32'h0000_0000, 6'h00, 6'h00}, {3'h5, 1'b0, 32'hFFFF_FFFF, 6'h00, 6'h00},
        {3'h6, 1'b0, 32'h43FF_FFFF, 6'h00, 6'h00}, {3'h6, 1'b0, 32'hC400_0000, 6'h00, 6'h00},
        {3'h6, 1'b0, 32'hB700_0000, 6'h00, 6'h00}, {3'h6, 1'b0, 32'h36FF_FFFF, 6'h00, 6'h00},
        {3'h6, 1'b0, 32'h3C7F_F000, 6'h00, 6'h00}, {3'h7, 1'b0, 32'h0000_0001, 6'h00, 6'h00},
        {3'h7, 1'b0, 32'h0000_8000, 6'h00, 6'h00}, {3'h7, 1'b0, 32'h0000_FFFF, 6'h00, 6'h00}
    };

    initial begin
        logic [31:0] r;
        logic [31:0] s;
        logic err;
        logic [2:0] op;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        mismatches = 0;
        compares = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'h1a50));
        apb(1'b0, shifter_pkg::CONTROL_OFS, 32'h0, r, err);
        check({10'h0, err, r}, {10'h0, 1'b0, 20'h0, shifter_pkg::FIELD_RST, shifter_pkg::FIELD_RST});
        s = $urandom;
        apb(1'b1, shifter_pkg::OPERAND_OFS, s, r, err);
        apb(1'b0, shifter_pkg::OPERAND_OFS, 32'h0, r, err);
        check({10'h0, err, r}, {10'h0, 1'b0, s});
        // Refused accesses: unmapped read and a write to a read-only word
        apb(1'b0, 12'hFFC, 32'h0, r, err);
        check({10'h0, err, r}, {10'h0, 1'b1, 32'h0});
        apb(1'b1, shifter_pkg::RESULT_FIXED_OFS, 32'hFFFF_FFFF, r, err);
        check({42'h0, err}, {42'h0, 1'b1});
        foreach (corners[i])
            run_op(corners[i][47:45], corners[i][44], corners[i][43:12], corners[i][11:6], corners[i][5:0]);
        for (int i = 0; i < 600; i++) begin
            op = 3'($urandom);
            s = $urandom;
            if (op inside {3'h2, 3'h3, 3'h4, 3'h5}) begin
                s = s >> ($urandom % 33);
                if ($urandom % 2)
                    s = ~s;
            end
            if (op == 3'h6)
                s[30:23] = ($urandom % 8 == 0) ? 8'hFF : 8'(8'h69 + $urandom % 36);
            if ($urandom % 8 == 0)
                run_op(op, 1'($urandom), s, 6'($urandom), 6'($urandom));
            else
                run_op(op, 1'($urandom), s, 6'($urandom % 40), 6'($urandom % 34));
        end
        give_verdict();
    end
endmodule
`default_nettype wire
